/* File: src/arx_pkg.sv */
// Shared constants and types of the two-axis excitation, unit-reset and store controller.
// Assumes a single 100 MHz clock and an AHB-Lite register bus with 32-bit data.
package arx_pkg;

    // Register byte offsets; axis registers take base + 4 * axis
    localparam logic [7:0] OFF_CMD = 8'h00;
    localparam logic [7:0] OFF_AXCMD = 8'h04;
    localparam logic [7:0] OFF_STAT = 8'h10;
    localparam logic [7:0] OFF_LPOS = 8'h18;
    localparam logic [7:0] OFF_RPOS = 8'h20;
    localparam logic [7:0] OFF_NVM = 8'h28;

    // Unit command word fields
    localparam int CMD_URST_BIT = 0;
    localparam int CMD_STORE_BIT = 1;
    localparam int CMD_SEL_LSB = 2;
    localparam int AXCMD_W = 10;

    // Speed preset selection range and reset value
    localparam logic [2:0] SPD_RST = 3'h1;
    localparam logic [2:0] SPD_MAX = 3'h5;

    // Nonvolatile map: program region, then configuration region
    localparam logic [7:0] PROG_FIRST = 8'h00;
    localparam logic [7:0] PROG_LAST = 8'h7f;
    localparam logic [7:0] CFG_FIRST = 8'h80;
    localparam logic [7:0] CFG_LAST = 8'hbf;

    // Step timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int STEP_PERIOD_NS = 10000;
    localparam int STEP_DIV = (STEP_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Per-axis command word, most significant field first; free_tgl is bit 0
    typedef struct packed {
        logic [2:0] spd;
        logic spd_wr;
        logic prog_start;
        logic split_tgl;
        logic dir;
        logic stop;
        logic start;
        logic free_tgl;
    } arx_axcmd_t;

    // Per-axis status word, most significant field first; excited is bit 0
    typedef struct packed {
        logic [2:0] spd;
        logic split_en;
        logic fault;
        logic prog_run;
        logic rotating;
        logic excited;
    } arx_axstat_t;

    typedef enum logic [1:0] {
        SEL_NONE = 2'b00,
        SEL_PROG = 2'b01,
        SEL_CFG = 2'b10,
        SEL_ALL = 2'b11
    } arx_sel_t;

    typedef enum logic [1:0] {
        NV_IDLE = 2'b00,
        NV_FETCH = 2'b01,
        NV_WRITE = 2'b10
    } arx_nvst_t;

    // One-hot hit of the two axis words of a register pair
    function automatic logic [1:0] arx_axsel(input logic [7:0] a, input logic [7:0] base);
        arx_axsel = {a == 8'(base + 8'h04), a == base};
    endfunction : arx_axsel

endpackage : arx_pkg

/* File: src/arx_axis.sv */
// One axis: excitation, rotation, program flag, fault, split enable, speed and position counters.
// Assumes commands and the unit reset arrive as one-cycle pulses in the hclk domain.
`timescale 1ns/1ps
module arx_axis
    import arx_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic urst,
    input wire logic cmd_vld,
    input arx_pkg::arx_axcmd_t cmd,
    input wire logic tick,
    input wire logic enc_step,
    input wire logic enc_dir,
    input wire logic step_err,
    input wire logic prog_done,
    output arx_pkg::arx_axstat_t stat,
    output logic signed [31:0] lpos,
    output logic signed [31:0] rpos,
    output logic pulse,
    output logic dir
);
    logic exc_q, rot_q, prog_q, fault_q, split_q, pulse_q, dir_q;
    logic [2:0] spd_q;
    logic signed [31:0] lpos_q, rpos_q;
    logic start_ok;

    // A start needs energised windings, no latched fault and no free request in the same word,
    // since that word would drop the windings on the very edge the rotation begins
    assign start_ok = cmd_vld && exc_q && !fault_q && !cmd.free_tgl;

    // Excitation toggles only while stopped; reset forces it on
    always_ff @(posedge hclk or negedge hresetn)
        if (!hresetn)
            exc_q <= 1'b1;
        else if (urst)
            exc_q <= 1'b1;
        else if (cmd_vld && cmd.free_tgl && !rot_q)
            exc_q <= !exc_q;

    // Rotation: halted at once by reset, stop or a step-out, no ramp
    always_ff @(posedge hclk or negedge hresetn)
        if (!hresetn)
        begin
            rot_q <= 1'b0;
            dir_q <= 1'b0;
        end
        else if (urst || step_err || (cmd_vld && cmd.stop))
            rot_q <= 1'b0;
        else if (start_ok && (cmd.start || cmd.prog_start))
        begin
            rot_q <= 1'b1;
            dir_q <= cmd.dir;
        end

    // Program run flag, ended by the sequencer or aborted by reset
    always_ff @(posedge hclk or negedge hresetn)
        if (!hresetn)
            prog_q <= 1'b0;
        else if (urst || prog_done)
            prog_q <= 1'b0;
        else if (start_ok && cmd.prog_start)
            prog_q <= 1'b1;

    // Fault set wins over the reset clear so a coincident step-out is kept
    always_ff @(posedge hclk or negedge hresetn)
        if (!hresetn)
            fault_q <= 1'b0;
        else if (step_err)
            fault_q <= 1'b1;
        else if (urst)
            fault_q <= 1'b0;

    // Split enable toggle and speed preset
    always_ff @(posedge hclk or negedge hresetn)
        if (!hresetn)
        begin
            split_q <= 1'b0;
            spd_q <= SPD_RST;
        end
        else if (urst)
        begin
            split_q <= 1'b0;
            spd_q <= SPD_RST;
        end
        else if (cmd_vld)
        begin
            if (cmd.split_tgl)
                split_q <= !split_q;
            if (cmd.spd_wr && cmd.spd != 3'h0 && cmd.spd <= SPD_MAX)
                spd_q <= cmd.spd;
        end

    // Step pulses and the commanded and measured position counters
    always_ff @(posedge hclk or negedge hresetn)
        if (!hresetn)
        begin
            pulse_q <= 1'b0;
            lpos_q <= '0;
            rpos_q <= '0;
        end
        else if (urst)
        begin
            pulse_q <= 1'b0;
            lpos_q <= '0;
            rpos_q <= '0;
        end
        else
        begin
            pulse_q <= rot_q && tick;
            if (rot_q && tick)
                lpos_q <= dir_q ? lpos_q - 32'sd1 : lpos_q + 32'sd1;
            if (enc_step)
                rpos_q <= enc_dir ? rpos_q - 32'sd1 : rpos_q + 32'sd1;
        end

    assign stat = '{spd: spd_q, split_en: split_q, fault: fault_q, prog_run: prog_q,
                    rotating: rot_q, excited: exc_q};
    assign lpos = lpos_q;
    assign rpos = rpos_q;
    assign pulse = pulse_q;
    assign dir = dir_q;

endmodule : arx_axis

/* File: src/arx_nvstore.sv */
// Store engine: copies the selected region word by word into nonvolatile memory.
// Assumes the source answers src_data combinationally for the address on addr.
`timescale 1ns/1ps
module arx_nvstore
    import arx_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic go,
    input arx_pkg::arx_sel_t sel,
    input wire logic [31:0] src_data,
    input wire logic ack,
    output logic we,
    output logic [7:0] addr,
    output logic [31:0] wdata,
    output logic busy,
    output logic done
);
    arx_nvst_t st_q;
    logic we_q, done_q;
    logic [7:0] addr_q, last_q;
    logic [31:0] wdata_q;

    // Walk the region word by word; a new go is ignored while busy
    always_ff @(posedge hclk or negedge hresetn)
        if (!hresetn)
        begin
            st_q <= NV_IDLE;
            we_q <= 1'b0;
            done_q <= 1'b0;
            addr_q <= 8'h00;
            last_q <= 8'h00;
            wdata_q <= 32'h0000_0000;
        end
        else
            unique case (st_q)
                NV_IDLE:
                    if (go && sel != SEL_NONE)
                    begin
                        st_q <= NV_FETCH;
                        done_q <= 1'b0;
                        addr_q <= (sel == SEL_CFG) ? CFG_FIRST : PROG_FIRST;
                        last_q <= (sel == SEL_PROG) ? PROG_LAST : CFG_LAST;
                    end
                NV_FETCH:
                begin
                    wdata_q <= src_data;
                    we_q <= 1'b1;
                    st_q <= NV_WRITE;
                end
                NV_WRITE:
                    if (ack)
                    begin
                        we_q <= 1'b0;
                        if (addr_q == last_q)
                        begin
                            st_q <= NV_IDLE;
                            done_q <= 1'b1;
                        end
                        else
                        begin
                            addr_q <= addr_q + 8'h01;
                            st_q <= NV_FETCH;
                        end
                    end
                default:
                    st_q <= NV_IDLE;
            endcase

    assign we = we_q;
    assign addr = addr_q;
    assign wdata = wdata_q;
    assign busy = (st_q != NV_IDLE);
    assign done = done_q;

endmodule : arx_nvstore

/* File: src/arx_ctrl.sv */
// Top of the two-axis excitation, unit-reset and store controller with its AHB-Lite register slave.
// Assumes one 100 MHz clock, asynchronous active-low reset and synchronous pin inputs.
//
// The register offsets and the AHB-Lite slave port are this design's own decisions.
`timescale 1ns/1ps
module arx_ctrl
    import arx_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic [1:0] enc_step,
    input wire logic [1:0] enc_dir,
    input wire logic [1:0] step_err,
    input wire logic [1:0] prog_done,
    output logic [1:0] step_pulse,
    output logic [1:0] step_dir,
    output logic [1:0] excite,
    output logic [1:0] split_en,
    input wire logic [31:0] nv_src_data,
    input wire logic nv_ack,
    output logic nv_we,
    output logic [7:0] nv_addr,
    output logic [31:0] nv_wdata
);
    logic ap_take, dp_wr_q, hit_q, rd_hit;
    logic [7:0] dp_addr_q;
    logic [31:0] rdata_q, rdata_d;
    logic urst, store_go, nv_busy, nv_done;
    logic [1:0] ax_vld;
    arx_axcmd_t ax_cmd;
    arx_axstat_t ax_stat [2];
    logic signed [31:0] ax_lpos [2];
    logic signed [31:0] ax_rpos [2];
    logic [1:0] ax_pulse, ax_dir;
    logic [9:0] div_q;
    logic tick_q;

    // Address phase is taken when the bus is ready; the low byte decodes and the upper 24 bits must be zero
    assign ap_take = hsel && htrans[1] && hready;
    assign rd_hit = (haddr[31:8] == 24'h00_0000);

    always_ff @(posedge hclk or negedge hresetn)
        if (!hresetn)
        begin
            dp_wr_q <= 1'b0;
            hit_q <= 1'b0;
            dp_addr_q <= 8'h00;
        end
        else if (hready)
        begin
            dp_wr_q <= ap_take && hwrite;
            hit_q <= rd_hit;
            dp_addr_q <= haddr[7:0];
        end

    // Zero wait state, always OKAY; unmapped writes are dropped
    always_ff @(posedge hclk or negedge hresetn)
        if (!hresetn)
        begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
        else
        begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end

    // Write strobes are decoded in the data phase straight from hwdata
    assign urst = dp_wr_q && hit_q && dp_addr_q == OFF_CMD && hwdata[CMD_URST_BIT];
    assign store_go = dp_wr_q && hit_q && dp_addr_q == OFF_CMD && hwdata[CMD_STORE_BIT];
    assign ax_vld = arx_axsel(dp_addr_q, OFF_AXCMD) & {2{dp_wr_q && hit_q}};
    assign ax_cmd = arx_axcmd_t'(hwdata[AXCMD_W-1:0]);

    // Read mux for the address phase; unmapped reads give zero
    always_comb
    begin
        rdata_d = 32'h0000_0000;
        if (rd_hit)
            unique case (haddr[7:0])
                OFF_STAT: rdata_d = {24'h00_0000, ax_stat[0]};
                OFF_STAT + 8'h04: rdata_d = {24'h00_0000, ax_stat[1]};
                OFF_LPOS: rdata_d = ax_lpos[0];
                OFF_LPOS + 8'h04: rdata_d = ax_lpos[1];
                OFF_RPOS: rdata_d = ax_rpos[0];
                OFF_RPOS + 8'h04: rdata_d = ax_rpos[1];
                OFF_NVM: rdata_d = {30'h0, nv_done, nv_busy};
                default: rdata_d = 32'h0000_0000;
            endcase
    end

    // Read data is registered so it stands through the data phase
    always_ff @(posedge hclk or negedge hresetn)
        if (!hresetn)
            rdata_q <= 32'h0000_0000;
        else if (ap_take && !hwrite)
            rdata_q <= rdata_d;

    assign hrdata = rdata_q;

    // Step-rate divider; one tick every STEP_DIV cycles shared by both axes
    always_ff @(posedge hclk or negedge hresetn)
        if (!hresetn)
        begin
            div_q <= 10'h000;
            tick_q <= 1'b0;
        end
        else if (div_q == 10'(STEP_DIV - 1))
        begin
            div_q <= 10'h000;
            tick_q <= 1'b1;
        end
        else
        begin
            div_q <= div_q + 10'h001;
            tick_q <= 1'b0;
        end

    // Both axes take the unit reset on the same edge
    for (genvar a = 0; a < 2; a++)
    begin : g_axis
        arx_axis u_axis (
            .hclk(hclk),
            .hresetn(hresetn),
            .urst(urst),
            .cmd_vld(ax_vld[a]),
            .cmd(ax_cmd),
            .tick(tick_q),
            .enc_step(enc_step[a]),
            .enc_dir(enc_dir[a]),
            .step_err(step_err[a]),
            .prog_done(prog_done[a]),
            .stat(ax_stat[a]),
            .lpos(ax_lpos[a]),
            .rpos(ax_rpos[a]),
            .pulse(ax_pulse[a]),
            .dir(ax_dir[a])
        );

        assign step_pulse[a] = ax_pulse[a];
        assign step_dir[a] = ax_dir[a];
        assign excite[a] = ax_stat[a].excited;
        assign split_en[a] = ax_stat[a].split_en;

        property p_free_toggle;
            @(posedge hclk) disable iff (!hresetn)
            ax_vld[a] && ax_cmd.free_tgl && !ax_stat[a].rotating && !urst
            |=> ax_stat[a].excited != $past(ax_stat[a].excited);
        endproperty
        a_free_toggle: assert property (p_free_toggle)
            else $error("free request did not toggle excitation");

        property p_hold_exc_rot;
            @(posedge hclk) disable iff (!hresetn)
            ax_stat[a].rotating && !urst |=> $stable(ax_stat[a].excited);
        endproperty
        a_hold_exc_rot: assert property (p_hold_exc_rot)
            else $error("excitation changed while rotating");

        property p_no_start_free;
            @(posedge hclk) disable iff (!hresetn)
            !ax_stat[a].excited && !ax_stat[a].rotating ##1 !ax_stat[a].excited
            |-> !ax_stat[a].rotating && !$rose(ax_stat[a].prog_run);
        endproperty
        a_no_start_free: assert property (p_no_start_free)
            else $error("rotation started on a free axis");

        property p_fault_latched;
            @(posedge hclk) disable iff (!hresetn)
            ax_stat[a].fault && !urst |=> ax_stat[a].fault;
        endproperty
        a_fault_latched: assert property (p_fault_latched)
            else $error("fault released without unit reset");

        property p_stop_now;
            @(posedge hclk) disable iff (!hresetn)
            urst |=> !ax_stat[a].rotating && !step_pulse[a] ##1 !step_pulse[a];
        endproperty
        a_stop_now: assert property (p_stop_now)
            else $error("pulses continued after unit reset");

        property p_prog_abort;
            @(posedge hclk) disable iff (!hresetn)
            urst |=> !ax_stat[a].prog_run;
        endproperty
        a_prog_abort: assert property (p_prog_abort)
            else $error("program still running after unit reset");

        property p_pos_clear;
            @(posedge hclk) disable iff (!hresetn)
            urst |=> ax_lpos[a] == 32'sd0 && ax_rpos[a] == 32'sd0;
        endproperty
        a_pos_clear: assert property (p_pos_clear)
            else $error("position counters not cleared");

        property p_spd_one;
            @(posedge hclk) disable iff (!hresetn)
            urst |=> ax_stat[a].spd == SPD_RST;
        endproperty
        a_spd_one: assert property (p_spd_one)
            else $error("speed preset not 1 after unit reset");

        property p_fault_clear;
            @(posedge hclk) disable iff (!hresetn)
            urst && !step_err[a] |=> !ax_stat[a].fault;
        endproperty
        a_fault_clear: assert property (p_fault_clear)
            else $error("fault not cleared by unit reset");

        property p_exc_on;
            @(posedge hclk) disable iff (!hresetn)
            urst |=> excite[a];
        endproperty
        a_exc_on: assert property (p_exc_on)
            else $error("excitation not forced on");

        property p_split_off;
            @(posedge hclk) disable iff (!hresetn)
            urst |=> !split_en[a];
        endproperty
        a_split_off: assert property (p_split_off)
            else $error("split pulse still enabled");

        property p_rot_excited;
            @(posedge hclk) disable iff (!hresetn)
            ax_stat[a].rotating |-> ax_stat[a].excited;
        endproperty
        a_rot_excited: assert property (p_rot_excited)
            else $error("axis rotating with windings free");

        property p_fault_set;
            @(posedge hclk) disable iff (!hresetn)
            step_err[a] |=> ax_stat[a].fault && !ax_stat[a].rotating;
        endproperty
        a_fault_set: assert property (p_fault_set)
            else $error("step-out did not latch fault and stop");

        property p_exc_cmd_only;
            @(posedge hclk) disable iff (!hresetn)
            !urst && !(ax_vld[a] && ax_cmd.free_tgl) |=> $stable(ax_stat[a].excited);
        endproperty
        a_exc_cmd_only: assert property (p_exc_cmd_only)
            else $error("excitation changed without a request");
    end

    // Store engine; a busy engine ignores a further store request
    arx_nvstore u_nvstore (
        .hclk(hclk),
        .hresetn(hresetn),
        .go(store_go),
        .sel(arx_sel_t'(hwdata[CMD_SEL_LSB+1:CMD_SEL_LSB])),
        .src_data(nv_src_data),
        .ack(nv_ack),
        .we(nv_we),
        .addr(nv_addr),
        .wdata(nv_wdata),
        .busy(nv_busy),
        .done(nv_done)
    );

    property p_store_start;
        @(posedge hclk) disable iff (!hresetn)
        store_go && !nv_busy && hwdata[CMD_SEL_LSB+1:CMD_SEL_LSB] != 2'b00
        |=> nv_busy ##1 nv_we;
    endproperty
    a_store_start: assert property (p_store_start)
        else $error("store request did not start a write");

    property p_store_hold;
        @(posedge hclk) disable iff (!hresetn)
        nv_we && !nv_ack |=> nv_we && $stable(nv_addr) && $stable(nv_wdata);
    endproperty
    a_store_hold: assert property (p_store_hold)
        else $error("store write dropped before acknowledge");

    property p_store_none;
        @(posedge hclk) disable iff (!hresetn)
        store_go && !nv_busy && hwdata[CMD_SEL_LSB+1:CMD_SEL_LSB] == 2'b00 |=> !nv_busy;
    endproperty
    a_store_none: assert property (p_store_none)
        else $error("empty selection started a store");

    property p_reset_together;
        @(posedge hclk) disable iff (!hresetn)
        urst |=> excite == 2'b11 && split_en == 2'b00 && !ax_stat[0].rotating && !ax_stat[1].rotating
                 && ax_stat[0].spd == SPD_RST && ax_stat[1].spd == SPD_RST;
    endproperty
    a_reset_together: assert property (p_reset_together)
        else $error("unit reset effects not simultaneous on both axes");

endmodule : arx_ctrl

/* File: dv/arx_nv_model.sv */
// Partner model of the nonvolatile memory and of the source buffer that feeds it.
// Assumes the controller holds nv_we until it samples nv_ack; lat sets the ack delay.
`timescale 1ns/1ps
module arx_nv_model
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic nv_we,
    input wire logic [7:0] nv_addr,
    input wire logic [3:0] lat,
    output logic [31:0] nv_src_data,
    output logic nv_ack
);
    logic [3:0] wait_q;

    // Word depends on address, so a wrong fetch shows in the written data
    assign nv_src_data = {4{nv_addr}} ^ 32'h1357_2468;

    // Ack after lat held cycles; large lat stalls the store engine
    assign nv_ack = nv_we && (wait_q == lat);

    // Count how long the current write has been held
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            wait_q <= 4'h0;
        else if (!nv_we || nv_ack)
            wait_q <= 4'h0;
        else
            wait_q <= wait_q + 4'h1;
    end
endmodule : arx_nv_model

/* File: dv/axis_reset_excitation_ctrl_test.sv */
// Self-checking bench of the excitation, unit-reset and store controller.
// Assumes a zero-wait AHB-Lite slave and the memory partner model beside it.
`timescale 1ns/1ps
module axis_reset_excitation_ctrl_test;
    import arx_pkg::*;
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, nv_ack, nv_we;
    logic [31:0] haddr, hwdata, hrdata, nv_src_data, nv_wdata, rdv;
    logic [1:0] htrans, enc_step, enc_dir, step_err, prog_done, step_pulse, step_dir, excite, split_en;
    logic [2:0] hsize;
    logic [7:0] nv_addr, exp_addr;
    logic [3:0] lat;
    int num_errors, checks_done, wr_cnt, pulses;

    arx_ctrl i_arx_ctrl (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .enc_step(enc_step), .enc_dir(enc_dir), .step_err(step_err),
        .prog_done(prog_done), .step_pulse(step_pulse), .step_dir(step_dir), .excite(excite),
        .split_en(split_en), .nv_src_data(nv_src_data), .nv_ack(nv_ack), .nv_we(nv_we), .nv_addr(nv_addr),
        .nv_wdata(nv_wdata));
    arx_nv_model i_arx_nv_model (.hclk(hclk), .hresetn(hresetn), .nv_we(nv_we), .nv_addr(nv_addr),
        .lat(lat), .nv_src_data(nv_src_data), .nv_ack(nv_ack));

    initial
    begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks_done++;
        if (got !== exp)
        begin
            num_errors++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk

    // Every accepted word must be the next ascending address with its source word
    always @(posedge hclk)
    begin
        if (step_pulse !== 2'b00)
            pulses++;
        if (nv_we === 1'b1 && nv_ack === 1'b1)
        begin
            chk(32'(nv_addr), 32'(exp_addr), "nv address");
            chk(nv_wdata, {4{nv_addr}} ^ 32'h1357_2468, "nv data");
            exp_addr = exp_addr + 8'h01;
            wr_cnt++;
        end
    end

    // One single transfer: address phase, then data phase; read data taken at its end
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= 32'(a);
        hwrite <= wr;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rdv = hrdata;
        chk(32'(hresp), 32'h0, "bus response");
    endtask : bus

    // Status bits: 0 excited, 1 rotating, 2 program, 3 fault, 4 split, 7:5 speed
    task automatic stat(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
        bus(1'b0, a, 32'h0);
        chk(32'(rdv[7:0] & m), 32'(e & m), "status");
    endtask : stat

    task automatic pulse_in(input logic [1:0] which, input bit err);
        @(posedge hclk);
        if (err)
            step_err <= which;
        else
            enc_step <= which;
        @(posedge hclk);
        step_err <= 2'b00;
        enc_step <= 2'b00;
    endtask : pulse_in

    task automatic t_free();
        stat(OFF_STAT, 8'h01, 8'h1f);
        stat(OFF_STAT + 8'h04, 8'h01, 8'h1f);
        bus(1'b0, 8'hfc, 32'h0);
        chk(rdv, 32'h0, "unmapped read");
        bus(1'b1, OFF_AXCMD, 32'h001);
        stat(OFF_STAT, 8'h00, 8'h01);
        chk(32'(excite), 32'h2, "excite pins off");
        bus(1'b1, OFF_AXCMD, 32'h002);
        bus(1'b1, OFF_AXCMD, 32'h020);
        stat(OFF_STAT, 8'h00, 8'h07);
        bus(1'b1, OFF_AXCMD, 32'h001);
        stat(OFF_STAT, 8'h01, 8'h03);
        bus(1'b1, OFF_AXCMD, 32'h003);
        stat(OFF_STAT, 8'h00, 8'h03);
        bus(1'b1, OFF_AXCMD, 32'h001);
    endtask : t_free

    task automatic t_rot_free();
        bus(1'b1, OFF_AXCMD + 8'h04, 32'h00a);
        stat(OFF_STAT + 8'h04, 8'h03, 8'h03);
        chk(32'(step_dir), 32'h2, "direction pin");
        bus(1'b1, OFF_AXCMD + 8'h04, 32'h001);
        stat(OFF_STAT + 8'h04, 8'h03, 8'h03);
        chk(32'(excite), 32'h3, "excite while rotating");
        bus(1'b1, OFF_AXCMD + 8'h04, 32'h004);
        stat(OFF_STAT + 8'h04, 8'h01, 8'h03);
    endtask : t_rot_free

    // X freed with a latched fault, Y running a program at speed 3 with split on
    task automatic t_unit_reset();
        bus(1'b1, OFF_AXCMD, 32'h001);
        pulse_in(2'b01, 1'b1);
        bus(1'b1, OFF_AXCMD + 8'h04, 32'h1c0);
        bus(1'b1, OFF_AXCMD + 8'h04, 32'h010);
        bus(1'b1, OFF_AXCMD + 8'h04, 32'h020);
        repeat (1100) @(posedge hclk);
        repeat (3) pulse_in(2'b10, 1'b0);
        enc_dir <= 2'b10;
        pulse_in(2'b10, 1'b0);
        enc_dir <= 2'b00;
        bus(1'b0, OFF_RPOS + 8'h04, 32'h0);
        chk(rdv, 32'h2, "real position count");
        stat(OFF_STAT, 8'h08, 8'h09);
        stat(OFF_STAT, 8'h08, 8'h09);
        stat(OFF_STAT + 8'h04, 8'h77, 8'hff);
        bus(1'b0, OFF_LPOS + 8'h04, 32'h0);
        chk(32'(rdv != 32'h0), 32'h1, "axis moved");
        chk(32'(pulses != 0), 32'h1, "pulses while rotating");
        bus(1'b1, OFF_CMD, 32'h001);
        #1;
        chk(32'({excite, split_en}), 32'hc, "pins at reset edge");
        pulses = 0;
        for (int ax = 0; ax < 2; ax++)
        begin
            stat(OFF_STAT + 8'(4 * ax), 8'h21, 8'hff);
            bus(1'b0, OFF_LPOS + 8'(4 * ax), 32'h0);
            chk(rdv, 32'h0, "logical position");
            bus(1'b0, OFF_RPOS + 8'(4 * ax), 32'h0);
            chk(rdv, 32'h0, "real position");
        end
        repeat (1100) @(posedge hclk);
        chk(32'(pulses), 32'h0, "pulses after reset");
    endtask : t_unit_reset

    // Each selection with a different memory latency; a second go while busy must be dropped
    task automatic t_store();
        arx_sel_t sels[3] = '{SEL_PROG, SEL_CFG, SEL_ALL};
        logic [7:0] firsts[3] = '{PROG_FIRST, CFG_FIRST, PROG_FIRST};
        logic [7:0] lasts[3] = '{PROG_LAST, CFG_LAST, CFG_LAST};
        int n;
        for (int i = 0; i < 3; i++)
        begin
            lat = 4'(3 * i);
            exp_addr = firsts[i];
            wr_cnt = 0;
            bus(1'b1, OFF_CMD, {28'h0, sels[i], 2'b10});
            bus(1'b1, OFF_CMD, {28'h0, SEL_PROG, 2'b10});
            n = 0;
            do
            begin
                bus(1'b0, OFF_NVM, 32'h0);
                n++;
            end
            while (rdv[0] !== 1'b0 && n < 3000);
            chk(32'(rdv[1:0]), 32'h2, "store done");
            chk(32'(wr_cnt), 32'(lasts[i] - firsts[i]) + 32'h1, "words stored");
        end
        bus(1'b1, OFF_CMD, {28'h0, SEL_NONE, 2'b10});
        repeat (8) @(posedge hclk);
        bus(1'b0, OFF_NVM, 32'h0);
        chk({31'h0, rdv[0]} | 32'(wr_cnt != 192), 32'h0, "empty select ignored");
    endtask : t_store

    task automatic conclude();
        $display("errors %0d checks %0d", num_errors, checks_done);
        if (num_errors == 0 && checks_done > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : conclude

    // Watchdog: the whole run needs well under 40000 cycles
    initial
    begin
        #400000;
        num_errors++;
        conclude();
    end

    initial
    begin
        hresetn = 1'b0;
        {hsel, hwrite, htrans, haddr, hwdata} = '0;
        hsize = 3'h2;
        {enc_step, enc_dir, step_err, prog_done} = '0;
        lat = 4'h0;
        exp_addr = 8'h00;
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        t_free();
        t_rot_free();
        t_unit_reset();
        t_store();
        conclude();
    end
endmodule : axis_reset_excitation_ctrl_test
